// File: clkoc_div_if.sv
// clkoc_div_if: settings into and state out of the channel divider
`timescale 1ns/10ps
interface clkoc_div_if;
    import clkoc_pkg::*;
    logic [DIV_W-1:0] setting;
    logic [PH_W-1:0] phase;
    logic powerdown;
    logic hold;
    logic freeze;
    logic tick;
    logic level;
    logic half_step;
    logic running;
    modport ctrl (output setting, phase, powerdown, hold, freeze,
                  input tick, level, half_step, running);
    modport div (input setting, phase, powerdown, hold, freeze,
                 output tick, level, half_step, running);
endinterface : clkoc_div_if

// File: clkoc_divider.sv
// clkoc_divider: programmable divider with sync hold and phase offset start delay
`timescale 1ns/10ps
module clkoc_divider
    import clkoc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    clkoc_div_if.div dif
);

    typedef struct packed {
        clkoc_dstate_t state;
        logic [DIV_W-1:0] cnt;
        logic [PH_W-2:0] dly;
        logic half;
        logic tick;
        logic level;
    } clkoc_div_state_t;

    clkoc_div_state_t st_ff;
    clkoc_div_state_t nxt_st;

    // ********************************************************************
    // next state
    // ********************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (dif.freeze) begin
            nxt_st = st_ff;
        end else if (dif.powerdown) begin
            nxt_st.state = CLKOC_DS_OFF;
            nxt_st.cnt = '0;
            nxt_st.level = 1'b0;
        end else if (dif.hold) begin
            // whole input-clock steps load the dly count, the odd half goes out on half_step
            nxt_st.state = CLKOC_DS_HOLD;
            nxt_st.cnt = '0;
            nxt_st.level = 1'b0;
            nxt_st.dly = dif.phase[PH_W-1:1];
            nxt_st.half = dif.phase[0];
        end else begin
            unique case (st_ff.state)
                CLKOC_DS_OFF: begin
                    nxt_st.state = CLKOC_DS_RUN;
                    nxt_st.tick = 1'b1;
                    nxt_st.level = 1'b1;
                end
                CLKOC_DS_HOLD: begin
                    nxt_st.state = CLKOC_DS_DELAY;
                end
                CLKOC_DS_DELAY: begin
                    if (st_ff.dly == '0) begin
                        nxt_st.state = CLKOC_DS_RUN;
                        nxt_st.tick = 1'b1;
                        nxt_st.level = 1'b1;
                    end else begin
                        nxt_st.dly = st_ff.dly - 1'b1;
                    end
                end
                CLKOC_DS_RUN: begin
                    // a setting lowered below the running count ends the period at once
                    // rather than letting the counter wrap through all 1024 states
                    if (st_ff.cnt >= dif.setting) begin
                        nxt_st.cnt = '0;
                        nxt_st.tick = 1'b1;
                        nxt_st.level = 1'b1;
                    end else begin
                        nxt_st.cnt = st_ff.cnt + 1'b1;
                        nxt_st.level = (st_ff.cnt + 1'b1) <= (dif.setting >> 1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{CLKOC_DS_OFF, '0, '0, 1'b0, 1'b0, 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dif.tick = st_ff.tick;
    assign dif.level = st_ff.level;
    assign dif.half_step = st_ff.half;
    assign dif.running = (st_ff.state == CLKOC_DS_RUN);

    // ********************************************************************
    // checks
    // ********************************************************************
    logic go_ok;
    assign go_ok = !dif.freeze && !dif.powerdown && !dif.hold;

    sequence s_released_p4;
        st_ff.state == CLKOC_DS_HOLD && go_ok && dif.phase[PH_W-1:1] == 10'h002;
    endsequence

    sequence s_tick_div2;
        dif.running && st_ff.tick && go_ok && dif.setting == 10'h001;
    endsequence

    AST_PHASE_START: assert property (@(posedge clk) disable iff (!rst_n)
        s_released_p4 |=> (!st_ff.tick)[*3] ##1 st_ff.tick)
        else $error("phase offset start not aligned");

    AST_DIV_TWO: assert property (@(posedge clk) disable iff (!rst_n)
        s_tick_div2 ##1 (go_ok && dif.setting == 10'h001) |-> !st_ff.tick ##1 st_ff.tick)
        else $error("divide by two period wrong");

    AST_PD_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        dif.powerdown && !dif.freeze |=> st_ff.state == CLKOC_DS_OFF && !st_ff.level)
        else $error("powered down divider still running");

    AST_HOLD_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        dif.hold && !dif.powerdown && !dif.freeze |=> !st_ff.level && !st_ff.tick)
        else $error("divider not held during sync");

endmodule : clkoc_divider

// File: clkoc_pkg.sv
// clkoc_pkg: register map, field positions, reset values and codes of the output channel block
package clkoc_pkg;

    // ********************************************************************
    // widths
    // ********************************************************************
    localparam int DIV_W = 10;
    localparam int PH_W = 11;

    // ********************************************************************
    // register offsets
    // ********************************************************************
    localparam logic [7:0] ADDR_REVISION = 8'h0A;
    localparam logic [7:0] ADDR_RSVD_REV = 8'h0B;
    localparam logic [7:0] ADDR_FAMILY_LO = 8'h0C;
    localparam logic [7:0] ADDR_FAMILY_HI = 8'h0D;
    localparam logic [7:0] ADDR_CHIP_RSVD = 8'h12;
    localparam logic [7:0] ADDR_SLEEP = 8'h13;
    localparam logic [7:0] ADDR_SYNC = 8'h14;
    localparam logic [7:0] ADDR_DIV_LO = 8'h15;
    localparam logic [7:0] ADDR_DIV_HI = 8'h16;
    localparam logic [7:0] ADDR_PH_LO = 8'h17;
    localparam logic [7:0] ADDR_PH_HI = 8'h18;
    localparam logic [7:0] ADDR_DRV = 8'h19;
    localparam logic [7:0] ADDR_SE = 8'h1A;

    // ********************************************************************
    // field positions and writable-bit masks
    // ********************************************************************
    localparam int SLEEP_BIT = 4;
    localparam int SYNC_N_BIT = 0;
    localparam int DRV_PD_BIT = 7;
    localparam int DRV_MASK_BIT = 6;
    localparam int DRV_POL_HI = 5;
    localparam int DRV_POL_LO = 4;
    localparam int DRV_STD_HI = 3;
    localparam int DRV_STD_LO = 1;
    localparam int SE_PEN_BIT = 7;
    localparam int SE_PPOL_HI = 6;
    localparam int SE_PPOL_LO = 5;
    localparam int SE_NEN_BIT = 4;
    localparam int SE_NPOL_HI = 3;
    localparam int SE_NPOL_LO = 2;
    localparam logic [7:0] MASK_SLEEP = 8'h10;
    localparam logic [7:0] MASK_SYNC = 8'h01;
    localparam logic [7:0] MASK_DIV_HI = 8'h03;
    localparam logic [7:0] MASK_PH_HI = 8'h07;
    localparam logic [7:0] MASK_DRV = 8'hFE;
    localparam logic [7:0] MASK_SE = 8'hFC;

    // ********************************************************************
    // reset values
    // ********************************************************************
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SYNC = 8'h01;
    localparam logic [7:0] RST_DRV = 8'h14;
    localparam logic [7:0] CHIP_RSVD_VAL = 8'h02;

    // ********************************************************************
    // polarity and driver standard codes
    // ********************************************************************
    localparam logic [1:0] POL_HIGH = 2'h0;
    localparam logic [1:0] POL_PASS = 2'h1;
    localparam logic [1:0] POL_INV = 2'h2;
    localparam logic [1:0] POL_LOW = 2'h3;
    localparam logic [2:0] STD_HIZ_FIRST = 3'h6;

    typedef enum logic [1:0] {CLKOC_DS_OFF, CLKOC_DS_HOLD, CLKOC_DS_DELAY, CLKOC_DS_RUN}
        clkoc_dstate_t;

    function automatic logic clkoc_pol(input logic [1:0] code, input logic lvl);
        logic r;
        r = 1'b0;
        unique case (code)
            POL_HIGH: r = 1'b1;
            POL_PASS: r = lvl;
            POL_INV: r = ~lvl;
            POL_LOW: r = 1'b0;
        endcase
        return r;
    endfunction : clkoc_pol

endpackage : clkoc_pkg

// File: clkoc_rx_model.sv
// clkoc_rx_model: receiver of the divided clock, measures period and counts rising edges
`timescale 1ns/10ps
module clkoc_rx_model (
    input wire logic clk,
    input wire logic din,
    output int period,
    output int edges
);
    int cnt = 0;
    logic prev = 1'b0;
    initial begin
        period = 0;
        edges = 0;
    end
    // sampled on the same edge that launches the pin, so the pre-edge level is seen
    always @(posedge clk) begin
        prev <= din;
        cnt <= cnt + 1;
        if (din === 1'b1 && prev === 1'b0) begin
            period <= cnt + 1;
            cnt <= 0;
            edges <= edges + 1;
        end
    end
endmodule : clkoc_rx_model

// File: clkoc_top.sv
// clkoc_top: registers, sleep, software sync and output drivers of one clock output channel
`timescale 1ns/10ps

// Contract
// - the divider setting is 10 bits, low 8 in one register and bits 9:8 in bits 1:0 of the next.
// - the input clock is divided by the setting plus one, 0 passing it and 1023 giving 1024; setting 0 here holds the output high with no edges.
// - an 11-bit phase offset, 8 low and 3 high bits, is applied in half input-clock steps.
// - sleep mode is on while bit 4 of the sleep register is one, reset value zero.
// - software output sync runs while the active-low sync bit 0 is zero; it resets to one.
// - sync-mask bit 6 at one leaves the divider out of sync; zero, its reset, includes it.
// - bit 7 of the driver control register powers the divider down.
// - driver field 5:4 forces high, passes, inverts or forces low the output, reset pass.
// - driver field 3:1 selects four LVDS levels, HSTL, boosted HSTL or high-Z/CMOS, reset 010.
// - the positive single-ended driver is enabled only while bit 7 is one, reset zero.
// - positive single-ended polarity field 6:5 uses the four polarity codes, reset force high.
// - the negative single-ended driver is enabled only while bit 4 is one, reset zero.
// - negative single-ended polarity field 3:2 uses the same codes, reset force high.
// - an 8-bit read-only revision register identifies the silicon revision.
// - a 16-bit read-only family identifier sits low byte then high byte in two registers.
module clkoc_top
    import clkoc_pkg::*;
#(
    parameter logic [7:0] REVISION_ID = 8'hA5,   // arbitrary value
    parameter logic [15:0] FAMILY_ID = 16'h3C96  // arbitrary value
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic sleep_active,
    output logic sw_sync_active,
    output logic [2:0] diff_standard,
    output logic diff_out,
    output logic diff_oe_n,
    output logic pos_out,
    output logic pos_oe_n,
    output logic neg_out,
    output logic neg_oe_n,
    output logic half_step
);

    // ********************************************************************
    // reset release
    // ********************************************************************
    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_ff[1];

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        logic [7:0] sleep;
        logic [7:0] sync;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] ph_lo;
        logic [7:0] ph_hi;
        logic [7:0] drv;
        logic [7:0] se;
        logic [7:0] rdata;
        logic diff_out;
        logic diff_oe_n;
        logic pos_out;
        logic pos_oe_n;
        logic neg_out;
        logic neg_oe_n;
    } clkoc_top_state_t;

    clkoc_top_state_t st_ff;
    clkoc_top_state_t nxt_st;

    clkoc_div_if dif ();

    logic asleep;
    logic wr_ok;
    logic [7:0] rd_mux;

    assign asleep = st_ff.sleep[SLEEP_BIT];
    // the sleep register itself stays writable, otherwise nothing could wake the block
    assign wr_ok = reg_wr && (!asleep || reg_addr == ADDR_SLEEP);

    // ********************************************************************
    // read decode
    // ********************************************************************
    always_comb begin
        rd_mux = RST_ZERO;
        unique case (reg_addr)
            ADDR_REVISION: rd_mux = REVISION_ID;
            ADDR_RSVD_REV: rd_mux = RST_ZERO;
            ADDR_FAMILY_LO: rd_mux = FAMILY_ID[7:0];
            ADDR_FAMILY_HI: rd_mux = FAMILY_ID[15:8];
            ADDR_CHIP_RSVD: rd_mux = CHIP_RSVD_VAL;
            ADDR_SLEEP: rd_mux = st_ff.sleep;
            ADDR_SYNC: rd_mux = st_ff.sync;
            ADDR_DIV_LO: rd_mux = st_ff.div_lo;
            ADDR_DIV_HI: rd_mux = st_ff.div_hi;
            ADDR_PH_LO: rd_mux = st_ff.ph_lo;
            ADDR_PH_HI: rd_mux = st_ff.ph_hi;
            ADDR_DRV: rd_mux = st_ff.drv;
            ADDR_SE: rd_mux = st_ff.se;
            default: rd_mux = RST_ZERO;
        endcase
    end

    // ********************************************************************
    // divider control
    // ********************************************************************
    assign dif.setting = {st_ff.div_hi[1:0], st_ff.div_lo};
    assign dif.phase = {st_ff.ph_hi[2:0], st_ff.ph_lo};
    assign dif.powerdown = st_ff.drv[DRV_PD_BIT];
    assign dif.hold = !st_ff.sync[SYNC_N_BIT] && !st_ff.drv[DRV_MASK_BIT];
    assign dif.freeze = asleep;

    clkoc_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .dif(dif)
    );

    // ********************************************************************
    // next state: register writes, read data, drivers
    // ********************************************************************
    always_comb begin
        nxt_st = st_ff;
        if (wr_ok) begin
            unique case (reg_addr)
                ADDR_SLEEP: nxt_st.sleep = reg_wdata & MASK_SLEEP;
                ADDR_SYNC: nxt_st.sync = reg_wdata & MASK_SYNC;
                ADDR_DIV_LO: nxt_st.div_lo = reg_wdata;
                ADDR_DIV_HI: nxt_st.div_hi = reg_wdata & MASK_DIV_HI;
                ADDR_PH_LO: nxt_st.ph_lo = reg_wdata;
                ADDR_PH_HI: nxt_st.ph_hi = reg_wdata & MASK_PH_HI;
                ADDR_DRV: nxt_st.drv = reg_wdata & MASK_DRV;
                ADDR_SE: nxt_st.se = reg_wdata & MASK_SE;
                default: nxt_st.sleep = st_ff.sleep;
            endcase
        end
        if (reg_rd) begin
            nxt_st.rdata = rd_mux;
        end
        // in sleep the pins keep the last driven levels
        if (!asleep) begin
            nxt_st.diff_out = clkoc_pol(st_ff.drv[DRV_POL_HI:DRV_POL_LO], dif.level);
            nxt_st.diff_oe_n = st_ff.drv[DRV_STD_HI:DRV_STD_LO] >= STD_HIZ_FIRST;
            nxt_st.pos_out = clkoc_pol(st_ff.se[SE_PPOL_HI:SE_PPOL_LO], dif.level);
            nxt_st.pos_oe_n = !st_ff.se[SE_PEN_BIT];
            nxt_st.neg_out = clkoc_pol(st_ff.se[SE_NPOL_HI:SE_NPOL_LO], dif.level);
            nxt_st.neg_oe_n = !st_ff.se[SE_NEN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{RST_ZERO, RST_SYNC, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
                       RST_DRV, RST_ZERO, RST_ZERO, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    assign reg_rdata = st_ff.rdata;
    assign sleep_active = asleep;
    assign sw_sync_active = !st_ff.sync[SYNC_N_BIT];
    assign diff_standard = st_ff.drv[DRV_STD_HI:DRV_STD_LO];
    assign diff_out = st_ff.diff_out;
    assign diff_oe_n = st_ff.diff_oe_n;
    assign pos_out = st_ff.pos_out;
    assign pos_oe_n = st_ff.pos_oe_n;
    assign neg_out = st_ff.neg_out;
    assign neg_oe_n = st_ff.neg_oe_n;
    assign half_step = dif.half_step;

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_wr(logic [7:0] a);
        reg_wr && !asleep && reg_addr == a;
    endsequence

    AST_DIV_LOW: assert property (s_wr(ADDR_DIV_LO) |=> dif.setting[7:0] == $past(reg_wdata))
        else $error("divider low byte not taken");

    AST_PH_LOW: assert property (s_wr(ADDR_PH_LO) |=> dif.phase[7:0] == $past(reg_wdata))
        else $error("phase low byte not taken");

    AST_SYNC_FLAG: assert property (
        s_wr(ADDR_SYNC) |=> sw_sync_active == !$past(reg_wdata[SYNC_N_BIT]))
        else $error("software sync flag wrong");

    AST_DIV_HIGH: assert property (
        s_wr(ADDR_DIV_HI) |=> dif.setting[9:8] == $past(reg_wdata[1:0]))
        else $error("divider high bits not taken");

    AST_PH_HIGH: assert property (
        s_wr(ADDR_PH_HI) |=> dif.phase[10:8] == $past(reg_wdata[2:0]) && st_ff.ph_hi[7:3] == 5'h00)
        else $error("phase high bits wrong");

    AST_SLEEP_ON: assert property (
        reg_wr && reg_addr == ADDR_SLEEP |=> sleep_active == $past(reg_wdata[SLEEP_BIT]))
        else $error("sleep bit not applied");

    AST_SYNC_HOLD: assert property (
        s_wr(ADDR_SYNC) && !reg_wdata[0] && !dif.powerdown && !dif.hold && !st_ff.drv[DRV_MASK_BIT]
        |=> ##1 !dif.level)
        else $error("software sync did not hold the divider");

    AST_MASKED: assert property (
        st_ff.drv[DRV_MASK_BIT] |-> !dif.hold)
        else $error("masked divider held by sync");

    AST_SLEEP_STILL: assert property (
        asleep |=> $stable(diff_out) && $stable(pos_out) && $stable(neg_out) && $stable(pos_oe_n))
        else $error("outputs moved during sleep");

    AST_SLEEP_REGS: assert property (
        asleep && reg_wr && reg_addr == ADDR_DRV |=> $stable(st_ff.drv))
        else $error("register written during sleep");

    AST_FORCE_HIGH: assert property (
        !asleep && st_ff.drv[DRV_POL_HI:DRV_POL_LO] == POL_HIGH |=> diff_out)
        else $error("force high not applied");

    AST_FORCE_LOW: assert property (
        !asleep && st_ff.drv[DRV_POL_HI:DRV_POL_LO] == POL_LOW |=> !diff_out)
        else $error("force low not applied");

    AST_HIZ: assert property (
        !asleep && st_ff.drv[3:2] == 2'h3 |=> diff_oe_n)
        else $error("high-Z mode still drives");

    AST_POS_EN: assert property (
        s_wr(ADDR_SE) ##1 !asleep |=> pos_oe_n == !$past(reg_wdata[SE_PEN_BIT], 2))
        else $error("positive leg enable wrong");

    AST_NEG_EN: assert property (
        s_wr(ADDR_SE) ##1 !asleep |=> neg_oe_n == !$past(reg_wdata[SE_NEN_BIT], 2))
        else $error("negative leg enable wrong");

    AST_REV: assert property (
        reg_rd && reg_addr == ADDR_REVISION |=> reg_rdata == REVISION_ID)
        else $error("revision read wrong");

    AST_FAMILY: assert property (
        reg_rd && reg_addr == ADDR_FAMILY_HI |=> reg_rdata == FAMILY_ID[15:8])
        else $error("family high byte read wrong");

    AST_FAMILY_LOW: assert property (
        reg_rd && reg_addr == ADDR_FAMILY_LO |=> reg_rdata == FAMILY_ID[7:0])
        else $error("family low byte read wrong");

endmodule : clkoc_top

// File: tb_clock_output_channel_ctrl.sv
// tb_clock_output_channel_ctrl: register and clock output checks of one output channel
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_clock_output_channel_ctrl;
    import clkoc_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic sleep_active, sw_sync_active, diff_out, diff_oe_n, pos_out, pos_oe_n;
    logic neg_out, neg_oe_n, half_step;
    logic [2:0] diff_standard;
    int n_fail = 0, check_count = 0, period, edges, e0;
    // identity values are arbitrary
    clkoc_top #(.REVISION_ID(8'h5A), .FAMILY_ID(16'h1234)) dut (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_active(sleep_active), .sw_sync_active(sw_sync_active),
        .diff_standard(diff_standard), .diff_out(diff_out), .diff_oe_n(diff_oe_n),
        .pos_out(pos_out), .pos_oe_n(pos_oe_n), .neg_out(neg_out), .neg_oe_n(neg_oe_n),
        .half_step(half_step));
    clkoc_rx_model rx (.clk(clk), .din(diff_out), .period(period), .edges(edges));
    initial begin
        forever #4 clk = ~clk;
    end
    // ********************************************************************
    // access tasks
    // ********************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        `CHK(reg_rdata, e)
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // bounded wait for n more rising edges at the receiver
    task automatic wedges(input int n, input int bound);
        int i;
        e0 = edges;
        for (i = 0; i < bound && edges < e0 + n; i++) @(posedge clk);
        #1;
        if (edges < e0 + n) begin
            n_fail++;
            $display("unexpected at %0t: clock edges missing", $time);
            summarize();
        end
    endtask : wedges
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    // ********************************************************************
    // main sequence
    // ********************************************************************
    logic [7:0] ra [13] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
        8'h17, 8'h18, 8'h19, 8'h1A};
    logic [7:0] rv [13] = '{8'h5A, 8'h00, 8'h34, 8'h12, 8'h02, 8'h00, 8'h01, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h14, 8'h00};
    int dv [4] = '{1, 2, 5, 1023};
    logic [3:0] pol_exp = 4'b0101;
    initial begin
        repeat (10) @(posedge clk);
        #1;
        arst_n = 1'b1;
        cyc(3);
        `CHK({sleep_active, sw_sync_active, diff_oe_n, pos_oe_n, neg_oe_n}, 5'h03)
        `CHK(diff_standard, 3'h2)
        for (int i = 0; i < 13; i++) rd(ra[i], rv[i]);
        rd(8'h30, 8'h00);
        wr(ADDR_REVISION, 8'hFF);
        wr(ADDR_FAMILY_HI, 8'hFF);
        rd(ADDR_REVISION, 8'h5A);
        rd(ADDR_FAMILY_HI, 8'h12);
        wr(ADDR_DIV_HI, 8'hFF);
        rd(ADDR_DIV_HI, 8'h03);
        wr(ADDR_PH_HI, 8'hFF);
        rd(ADDR_PH_HI, 8'h07);
        wr(ADDR_PH_HI, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_DIV_LO, dv[i][7:0]);
            wr(ADDR_DIV_HI, {6'h00, dv[i][9:8]});
            wedges(3, 4000);
            `CHK(period, dv[i] + 1)
        end
        wr(ADDR_DIV_HI, 8'h00);
        wr(ADDR_DIV_LO, 8'h00);
        cyc(4);
        e0 = edges;
        cyc(20);
        `CHK({diff_out, edges - e0}, {1'b1, 32'h0})
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_DRV, {4'h1, s[2:0], 1'b0});
            cyc(2);
            `CHK({diff_standard, diff_oe_n}, {s[2:0], s >= 6})
        end
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_DRV, {2'h2, p[1:0], 4'h4});
            wr(ADDR_SE, {1'b1, p[1:0], 1'b1, p[1:0], 2'h0});
            cyc(3);
            `CHK({diff_out, pos_out, neg_out}, {3{pol_exp[p]}})
            `CHK({pos_oe_n, neg_oe_n}, 2'h0)
        end
        wr(ADDR_SE, 8'h00);
        wr(ADDR_DRV, 8'h14);
        wr(ADDR_DIV_LO, 8'h03);
        wr(ADDR_PH_LO, 8'h05);
        wedges(2, 100);
        wr(ADDR_SYNC, 8'h00);
        cyc(4);
        e0 = edges;
        cyc(20);
        `CHK({sw_sync_active, diff_out, edges - e0}, {2'h2, 32'h0})
        wr(ADDR_SYNC, 8'h01);
        wedges(2, 100);
        `CHK({sw_sync_active, half_step, period}, {2'h1, 32'h4})
        wr(ADDR_DRV, 8'h54);
        wr(ADDR_SYNC, 8'h00);
        wedges(3, 100);
        `CHK(period, 4)
        wr(ADDR_SYNC, 8'h01);
        wr(ADDR_SLEEP, 8'h10);
        cyc(2);
        e0 = edges;
        cyc(20);
        `CHK({sleep_active, edges - e0}, {1'b1, 32'h0})
        wr(ADDR_DIV_LO, 8'h07);
        rd(ADDR_DIV_LO, 8'h03);
        wr(ADDR_SLEEP, 8'h00);
        wedges(2, 100);
        `CHK({sleep_active, period}, {1'b0, 32'h4})
        summarize();
    end
endmodule : tb_clock_output_channel_ctrl
